// *** core/ars_obj_mem.sv ***
// Purpose: Object store holding the ASCII value of each object
// Assumes: One write port, one read port, registered read data
// Notes:   Contents return to the reset value on reset
`timescale 1ns/1ns
module ars_obj_mem #(
  parameter int          WIDTH = 40,
  parameter int          DEPTH = ars_pkg::ARS_OBJ_DEPTH,
  parameter int          AW    = 3,
  parameter logic [39:0] RST   = ars_pkg::ARS_DATA_RST
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  import ars_pkg::*;

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Storage array
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= RST[WIDTH-1:0];
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= RST[WIDTH-1:0];
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule

// *** core/ars_pkg.sv ***
// Purpose: Shared constants and types for the ASCII request responder
// Assumes: Characters are 8-bit ASCII codes
// Notes:   Frame is STX, address, request, command, data, ETX, check char
package ars_pkg;
  // Frame control characters, request letters and digit bounds
  localparam logic [7:0]  ARS_STX       = 8'h02;
  localparam logic [7:0]  ARS_ETX       = 8'h03;
  localparam logic [7:0]  ARS_ACK       = 8'h06;
  localparam logic [7:0]  ARS_NAK       = 8'h15;
  localparam logic [7:0]  ARS_CH_R      = 8'h52;
  localparam logic [7:0]  ARS_CH_W      = 8'h57;
  localparam logic [7:0]  ARS_CH_0      = 8'h30;
  localparam logic [7:0]  ARS_CH_9      = 8'h39;
  // Exception codes, sent as ASCII digits
  localparam logic [7:0]  ARS_EXC_EQUIP = 8'h30;
  localparam logic [7:0]  ARS_EXC_MEM   = 8'h31;
  localparam logic [7:0]  ARS_EXC_RANGE = 8'h32;
  localparam logic [7:0]  ARS_EXC_DENY  = 8'h33;
  // Field positions in the receive buffer (after STX), then request and reply frame lengths
  localparam logic [3:0]  ARS_IX_REQ    = 4'h2;
  localparam logic [3:0]  ARS_IX_OBJ    = 4'h5;
  localparam logic [3:0]  ARS_RD_LEN    = 4'h6;
  localparam logic [3:0]  ARS_WR_LEN    = 4'hb;
  localparam logic [3:0]  ARS_ACK_RD    = 4'hd;
  localparam logic [3:0]  ARS_ACK_WR    = 4'h8;
  localparam logic [3:0]  ARS_NAK_LEN   = 4'h6;
  localparam int          ARS_RESP_MAX  = 13;
  // Defaults: own address "01", command prefix "PV", limit "50000"
  localparam logic [15:0] ARS_ADDR_DEF  = 16'h3031;
  localparam logic [15:0] ARS_PFX_DEF   = 16'h5056;
  localparam logic [39:0] ARS_RANGE_DEF = 40'h3530303030;
  localparam logic [39:0] ARS_DATA_RST  = 40'h3030303030;
  localparam int          ARS_OBJ_DEPTH = 8;
  // Frame handling states
  typedef enum logic [2:0] {
    ARS_IDLE, ARS_RX, ARS_BCC, ARS_READ, ARS_DECIDE, ARS_TX
  } ars_state_t;
endpackage

// *** core/ars_responder.sv ***
// What this block does
// - Write stores frame data into named object
// - Read returns object value in response data
// - Check char is XOR of STX through ETX
// - No check char sent when option off
// - Error-free request answered with ACK 06h
// - Erroneous request answered with NAK instead, except a bad check char or overlong frame: no reply
// - Error response carries an exception code
// - Equipment fault code 0; memory fault own code
// - Out-of-range write rejected with range exception
// - All fields are ASCII characters
// Purpose: Slave side of an ASCII serial request/response protocol
// Assumes: Byte stream from a receiver and to a transmitter, same clock
// Notes:   Frames addressed elsewhere are dropped without reply
`timescale 1ns/1ns
module ars_responder #(
  parameter logic [15:0] MY_ADDR  = ars_pkg::ARS_ADDR_DEF,
  parameter logic [15:0] CMD_PFX  = ars_pkg::ARS_PFX_DEF,
  parameter logic [39:0] RANGE_HI = ars_pkg::ARS_RANGE_DEF,
  parameter int          DEPTH    = ars_pkg::ARS_OBJ_DEPTH
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Received characters
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  // Transmitted characters
  input  wire logic       tx_ready,
  output logic            tx_valid,
  output logic      [7:0] tx_data,
  // Option and fault pins
  input  wire logic       bcc_sel,
  input  wire logic       equip_fault,
  input  wire logic       mem_fault,
  // Status
  output logic            frame_err
);
  import ars_pkg::*;

  logic             rst_q1, rst_sync_n;
  logic [2:0]       pin_s1, pin_s2, pin_s3, pin_f;
  ars_state_t       state_q;
  logic [3:0]       idx_q, len_q, tx_idx_q, resp_len_q;
  logic [7:0]       buf_q [11];
  logic [7:0]       resp_q [ARS_RESP_MAX];
  logic [7:0]       resp_d [ARS_RESP_MAX];
  logic [3:0]       resp_len_d;
  logic [7:0]       calc_q, tx_bcc_q, exc_d, obj_off;
  logic             bcc_mode_q, bcc_sent_q, wr_en, is_rd, is_wr, obj_ok;
  logic             digits_ok, in_range, err_d, tx_fire, tx_last;
  logic [39:0]      wdata, rdata;

  // Reset release through two flip-flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1     <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_q1     <= 1'b1;
      rst_sync_n <= rst_q1;
    end
  end

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
      pin_f  <= 3'h0;
    end else begin
      pin_s1 <= {mem_fault, equip_fault, bcc_sel};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_f & (pin_s2 ^ pin_s3));
    end
  end

  // Request decode and error classification
  always_comb begin
    wdata     = {buf_q[6], buf_q[7], buf_q[8], buf_q[9], buf_q[10]};
    obj_off   = buf_q[ARS_IX_OBJ] - ARS_CH_0;
    obj_ok    = ({buf_q[3], buf_q[4]} == CMD_PFX) &&
                (buf_q[ARS_IX_OBJ] >= ARS_CH_0) && (obj_off < 8'(DEPTH));
    is_rd     = (buf_q[ARS_IX_REQ] == ARS_CH_R) && (len_q == ARS_RD_LEN);
    is_wr     = (buf_q[ARS_IX_REQ] == ARS_CH_W) && (len_q == ARS_WR_LEN);
    digits_ok = 1'b1;
    for (int i = 6; i < 11; i++) begin
      if (buf_q[i] < ARS_CH_0 || buf_q[i] > ARS_CH_9) begin
        digits_ok = 1'b0;
      end
    end
    in_range = digits_ok && (wdata <= RANGE_HI);
    err_d    = 1'b1;
    if (pin_f[1]) begin
      exc_d = ARS_EXC_EQUIP;
    end else if (pin_f[2]) begin
      exc_d = ARS_EXC_MEM;
    end else if (!(is_rd || is_wr) || !obj_ok) begin
      exc_d = ARS_EXC_DENY;
    end else if (is_wr && !in_range) begin
      exc_d = ARS_EXC_RANGE;
    end else begin
      exc_d = ARS_CH_0;
      err_d = 1'b0;
    end
  end

  assign wr_en = (state_q == ARS_DECIDE) && !err_d && is_wr;

  // Response frame assembly
  always_comb begin
    for (int i = 0; i < ARS_RESP_MAX; i++) resp_d[i] = ARS_ETX;
    resp_d[0] = ARS_STX;
    resp_d[1] = buf_q[0];
    resp_d[2] = buf_q[1];
    resp_d[3] = err_d ? ARS_NAK : ARS_ACK;
    resp_d[4] = err_d ? exc_d : buf_q[3];
    resp_d[5] = err_d ? ARS_ETX : buf_q[4];
    resp_d[6] = buf_q[ARS_IX_OBJ];
    for (int i = 0; i < 5; i++) begin
      resp_d[7 + i] = is_rd ? rdata[39 - 8*i -: 8] : ARS_ETX;
    end
    resp_len_d = err_d ? ARS_NAK_LEN : (is_rd ? ARS_ACK_RD : ARS_ACK_WR);
  end

  // Frame receive and sequencing
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q    <= ARS_IDLE;
      idx_q      <= 4'h0;
      len_q      <= 4'h0;
      calc_q     <= 8'h00;
      bcc_mode_q <= 1'b0;
      frame_err  <= 1'b0;
      for (int i = 0; i < 11; i++) buf_q[i] <= 8'h00;
    end else begin
      frame_err <= 1'b0;
      case (state_q)
        ARS_IDLE: begin
          if (rx_valid && rx_data == ARS_STX) begin
            calc_q     <= ARS_STX;
            idx_q      <= 4'h0;
            bcc_mode_q <= pin_f[0];
            state_q    <= ARS_RX;
          end
        end
        ARS_RX: begin
          if (rx_valid) begin
            if (rx_data == ARS_STX) begin
              calc_q <= ARS_STX;
              idx_q  <= 4'h0;
            end else if (rx_data == ARS_ETX) begin
              calc_q  <= calc_q ^ rx_data;
              len_q   <= idx_q;
              state_q <= bcc_mode_q ? ARS_BCC : ARS_READ;
            end else if (idx_q == ARS_WR_LEN) begin
              frame_err <= 1'b1;
              state_q   <= ARS_IDLE;
            end else begin
              buf_q[idx_q] <= rx_data;
              calc_q       <= calc_q ^ rx_data;
              idx_q        <= idx_q + 4'h1;
            end
          end
        end
        ARS_BCC: begin
          if (rx_valid) begin
            if (rx_data == calc_q) begin
              state_q <= ARS_READ;
            end else begin
              frame_err <= 1'b1;
              state_q   <= ARS_IDLE;
            end
          end
        end
        ARS_READ: begin
          state_q <= ({buf_q[0], buf_q[1]} == MY_ADDR) ? ARS_DECIDE
                                                       : ARS_IDLE;
        end
        ARS_DECIDE: state_q <= ARS_TX;
        ARS_TX: if (tx_last) state_q <= ARS_IDLE;
        default: state_q <= ARS_IDLE;
      endcase
    end
  end

  assign tx_fire = tx_valid && tx_ready;
  assign tx_last = tx_fire && (tx_idx_q == resp_len_q) &&
                   (!bcc_mode_q || bcc_sent_q);

  // Response capture and transmit stream
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_valid   <= 1'b0;
      tx_data    <= 8'h00;
      tx_idx_q   <= 4'h0;
      tx_bcc_q   <= 8'h00;
      bcc_sent_q <= 1'b0;
      resp_len_q <= 4'h0;
      for (int i = 0; i < ARS_RESP_MAX; i++) resp_q[i] <= 8'h00;
    end else if (state_q == ARS_DECIDE) begin
      resp_q     <= resp_d;
      resp_len_q <= resp_len_d;
      tx_valid   <= 1'b1;
      tx_data    <= ARS_STX;
      tx_bcc_q   <= ARS_STX;
      tx_idx_q   <= 4'h1;
      bcc_sent_q <= 1'b0;
    end else if (tx_fire) begin
      if (tx_idx_q < resp_len_q) begin
        tx_data  <= resp_q[tx_idx_q];
        tx_bcc_q <= tx_bcc_q ^ resp_q[tx_idx_q];
        tx_idx_q <= tx_idx_q + 4'h1;
      end else if (bcc_mode_q && !bcc_sent_q) begin
        tx_data    <= tx_bcc_q;
        bcc_sent_q <= 1'b1;
      end else begin
        tx_valid <= 1'b0;
      end
    end
  end

  // Object store
  ars_obj_mem #(
    .WIDTH (40),
    .DEPTH (DEPTH),
    .AW    (3),
    .RST   (ARS_DATA_RST)
  ) u_mem (
    .clock   (clock),
    .rst_n   (rst_sync_n),
    .wr_en   (wr_en),
    .wr_addr (obj_off[2:0]),
    .wr_data (wdata),
    .rd_addr (obj_off[2:0]),
    .rd_data (rdata)
  );

  // Checks on decision and stream
  property p_ack;
    @(posedge clock) disable iff (!rst_sync_n)
    (state_q == ARS_DECIDE && !err_d) |=> (resp_q[3] == 8'h06);
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_nak;
    @(posedge clock) disable iff (!rst_sync_n)
    (state_q == ARS_DECIDE && err_d) |=> (resp_q[3] == 8'h15);
  endproperty
  a_nak: assert property (p_nak) else $error("nak missing");
  property p_exc;
    @(posedge clock) disable iff (!rst_sync_n)
    (state_q == ARS_DECIDE && err_d) |=>
      (resp_q[4] == $past(exc_d)) && (resp_len_q == 4'h6);
  endproperty
  a_exc: assert property (p_exc) else $error("exception code lost");
  property p_equip;
    @(posedge clock) disable iff (!rst_sync_n)
    (state_q == ARS_DECIDE && pin_f[1]) |=> (resp_q[4] == 8'h30);
  endproperty
  a_equip: assert property (p_equip) else $error("equip code");
  property p_range;
    @(posedge clock) disable iff (!rst_sync_n)
    wr_en |-> (digits_ok && wdata <= RANGE_HI && !pin_f[1] && !pin_f[2]);
  endproperty
  a_range: assert property (p_range) else $error("bad write taken");
  property p_read;
    @(posedge clock) disable iff (!rst_sync_n)
    (state_q == ARS_DECIDE && !err_d && is_rd) |=>
      ({resp_q[7], resp_q[8], resp_q[9], resp_q[10], resp_q[11]} ==
       $past(rdata)) && (resp_q[12] == 8'h03);
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");
  property p_bad_bcc;
    @(posedge clock) disable iff (!rst_sync_n)
    (state_q == ARS_BCC && rx_valid && rx_data != calc_q) |=>
      (state_q == ARS_IDLE && frame_err) ##1 !tx_valid;
  endproperty
  a_bad_bcc: assert property (p_bad_bcc) else $error("bad bcc kept");
  property p_no_bcc;
    @(posedge clock) disable iff (!rst_sync_n)
    (!bcc_mode_q && tx_fire && tx_data == 8'h03) |=> !tx_valid;
  endproperty
  a_no_bcc: assert property (p_no_bcc) else $error("extra char");
  property p_bcc_val;
    @(posedge clock) disable iff (!rst_sync_n)
    (tx_valid && bcc_sent_q) |-> (tx_data == tx_bcc_q) &&
      (resp_q[resp_len_q - 4'h1] == 8'h03);
  endproperty
  a_bcc_val: assert property (p_bcc_val) else $error("bcc value");
endmodule

// *** tb/ars_host_model.sv ***
// Purpose: Host master model sending request frames and taking replies
// Assumes: Shares the responder clock; driven through its tasks
// Notes:   Request line shows inverted last char when released
`timescale 1ns/1ns
module ars_host_model (
  // Clock
  input  wire logic       clock,
  // Request stream
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  // Response stream
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  import ars_pkg::*;
  logic [7:0] resp_q[$];

  // Idle lines at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // Frame a body with STX, ETX and optional (maybe corrupted) check char
  task automatic send(input logic [7:0] body[$], input bit bcc,
                      input bit bad);
    logic [7:0] f[$];
    logic [7:0] x;
    f = body;
    f.push_front(ARS_STX);
    f.push_back(ARS_ETX);
    x = 8'h00;
    foreach (f[i]) x = x ^ f[i];
    if (bad) x = ~x;
    if (bcc) f.push_back(x);
    foreach (f[i]) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data  <= f[i];
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_data  <= ~f[f.size()-1];
  endtask

  // Take reply chars, stalling every other cycle when slow
  task automatic collect(input bit slow, input int limit);
    resp_q.delete();
    repeat (limit) begin
      @(negedge clock);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) resp_q.push_back(tx_data);
      else if (resp_q.size() > 0 && tx_valid !== 1'b1) break;
      @(posedge clock);
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    @(posedge clock);
    tx_ready <= 1'b0;
  endtask
endmodule

// *** tb/ars_responder_test.sv ***
// Purpose: Self-checking bench for the ASCII request responder
// Assumes: Host model drives requests; bench drives option and fault pins
// Notes:   Expected replies are rebuilt here from the frame layout
`timescale 1ns/1ns
module ars_responder_test;
  import ars_pkg::*;
  typedef logic [7:0] ars_bytes_t[$];
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

  logic       clock;
  logic       rst_n;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       tx_ready;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       bcc_sel;
  logic       equip_fault;
  logic       mem_fault;
  logic       frame_err;
  int         err_count;
  int         n_checks;
  int         fe_cnt;
  int         cyc;

  ars_responder ars_responder_i (
    .clock       (clock),
    .rst_n       (rst_n),
    .rx_valid    (rx_valid),
    .rx_data     (rx_data),
    .tx_ready    (tx_ready),
    .tx_valid    (tx_valid),
    .tx_data     (tx_data),
    .bcc_sel     (bcc_sel),
    .equip_fault (equip_fault),
    .mem_fault   (mem_fault),
    .frame_err   (frame_err)
  );

  ars_host_model ars_host_model_i (
    .clock    (clock),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .tx_valid (tx_valid),
    .tx_data  (tx_data),
    .tx_ready (tx_ready)
  );

  // Clock, error pulse count and hang guard
  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (frame_err === 1'b1) fe_cnt <= fe_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      finish_test();
    end
  end

  // Report counts and verdict, then stop
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // String to char queue
  function automatic ars_bytes_t to_q(input string s);
    ars_bytes_t q;
    for (int i = 0; i < s.len(); i++) q.push_back(s[i]);
    return q;
  endfunction

  // Expected reply: STX, address, code, payload, ETX, optional check
  function automatic ars_bytes_t exp_frame(input logic [7:0] code,
                                           input string pay, input bit bcc);
    ars_bytes_t q;
    logic [7:0] x;
    q = to_q({"01", pay});
    q.insert(2, code);
    q.push_front(ARS_STX);
    q.push_back(ARS_ETX);
    x = 8'h00;
    foreach (q[i]) x = x ^ q[i];
    if (bcc) q.push_back(x);
    return q;
  endfunction

  // Set pins, then let the input filters settle
  task automatic set_pins(input bit b, input bit e, input bit m);
    @(posedge clock);
    bcc_sel     <= b;
    equip_fault <= e;
    mem_fault   <= m;
    repeat (6) @(posedge clock);
  endtask

  // One request and its reply
  task automatic run(input string req, input bit bcc, input bit slow);
    ars_host_model_i.send(to_q(req), bcc, 1'b0);
    ars_host_model_i.collect(slow, 60);
  endtask

  // Compare the collected reply with the expected one
  task automatic chk_resp(input ars_bytes_t e);
    `CHK(ars_host_model_i.resp_q.size(), e.size())
    foreach (e[i])
      if (i < ars_host_model_i.resp_q.size())
        `CHK(ars_host_model_i.resp_q[i], e[i])
  endtask

  // Write then read back one object, reader stalling
  task automatic t_write_read();
    set_pins(1'b1, 1'b0, 1'b0);
    run("01WPV312345", 1'b1, 1'b0);
    chk_resp(exp_frame(ARS_ACK, "PV3", 1'b1));
    run("01RPV3", 1'b1, 1'b1);
    chk_resp(exp_frame(ARS_ACK, "PV312345", 1'b1));
    $display("test write_read done");
  endtask

  // Check char option off: reply has none
  task automatic t_no_bcc();
    set_pins(1'b0, 1'b0, 1'b0);
    run("01RPV7", 1'b0, 1'b0);
    chk_resp(exp_frame(ARS_ACK, "PV700000", 1'b0));
    $display("test no_bcc done");
  endtask

  // Write just above the limit is refused and not stored
  task automatic t_range();
    set_pins(1'b1, 1'b0, 1'b0);
    run("01WPV550001", 1'b1, 1'b0);
    chk_resp(exp_frame(ARS_NAK, "2", 1'b1));
    run("01RPV5", 1'b1, 1'b0);
    chk_resp(exp_frame(ARS_ACK, "PV500000", 1'b1));
    run("01RPV9", 1'b1, 1'b0);
    chk_resp(exp_frame(ARS_NAK, "3", 1'b1));
    $display("test range done");
  endtask

  // Fault pins give their exception codes, equipment first
  task automatic t_faults();
    set_pins(1'b1, 1'b1, 1'b0);
    run("01RPV1", 1'b1, 1'b0);
    chk_resp(exp_frame(ARS_NAK, "0", 1'b1));
    set_pins(1'b1, 1'b0, 1'b1);
    run("01RPV1", 1'b1, 1'b0);
    chk_resp(exp_frame(ARS_NAK, "1", 1'b1));
    set_pins(1'b1, 1'b1, 1'b1);
    run("01WPV112345", 1'b1, 1'b0);
    chk_resp(exp_frame(ARS_NAK, "0", 1'b1));
    set_pins(1'b1, 1'b0, 1'b0);
    $display("test faults done");
  endtask

  // Corrupt check char: no reply, one error pulse, then recovery
  task automatic t_bad_bcc();
    int fe0;
    fe0 = fe_cnt;
    ars_host_model_i.send(to_q("01WPV212345"), 1'b1, 1'b1);
    ars_host_model_i.collect(1'b0, 40);
    `CHK(ars_host_model_i.resp_q.size(), 0)
    `CHK(fe_cnt - fe0, 1)
    run("01RPV2", 1'b1, 1'b0);
    chk_resp(exp_frame(ARS_ACK, "PV200000", 1'b1));
    $display("test bad_bcc done");
  endtask

  // Reset, then the scenarios
  initial begin
    clock       = 1'b0;
    rst_n       = 1'b0;
    bcc_sel     = 1'b0;
    equip_fault = 1'b0;
    mem_fault   = 1'b0;
    err_count   = 0;
    n_checks    = 0;
    fe_cnt      = 0;
    cyc         = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    @(negedge clock);
    `CHK(tx_valid, 1'b0)
    `CHK(frame_err, 1'b0)
    t_write_read();
    t_no_bcc();
    t_range();
    t_faults();
    t_bad_bcc();
    finish_test();
  end
endmodule
